// File: rtl/lamp_pkg.sv
// Purpose: Shared constants for the front-panel lamp controller.
// Assumes: One 250 MHz clock; all times are converted to cycle counts here.
// Notes:   Counts above 4096 cycles are defaults of top-level parameters.
//
// Notes on behaviour
// - Supply lamp follows the 5 V input only, never the 3.3 V output.
// - Health lamp steady once checks pass; dark on a processor problem.
// - Health lamp blinks fast while power-up self-checks run.
// - Health lamp blinks slow while I/O modules are being configured.
// - Boot mode: health and green run lamps blink together, in phase.
// - Run lamp green in run mode, amber in stopped mode with I/O scan.
// - Stopped without I/O scan: run lamp dark, health lamp lit.
// - Stop-to-run with fatal fault: run flashes green; a toggle then runs.
// - Fault lamp lit while stopped-faulted by a fatal fault.
// - Fault lamp goes out only after both fault tables are cleared.
// - Fatal fault in self-checks: fault lamp blinks, health lamp dark.
// - Override lamp lit while any bit reference is overridden.
// - Port lamps blink on traffic; port 1 ignores console traffic.
// - Restart when operational: network lamps briefly amber, then green.
// - Software load: all three network lamps blink green in unison.
// - Link lamp green, blinking on activity, while online; dark offline.
// - Status lamp green without exception, amber with an exception.
// - Status lamp blinks amber for an error code, green awaiting setup.
// - Ownership lamp amber when console owns port 1; dark for processor.
// - Press under 5 s resets network hardware and, when operational, runs the lamp test.
// - Press of 5 s or more toggles port 1 forced console use unless port 1 is configured for the console.
// - Retry window: run lamp blinks 5 s, then dark if not toggled.
package lamp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned CLK_KHZ       = 1000000 / CLK_PERIOD_NS;

    localparam int unsigned HOLD_MS      = 5000;
    localparam int unsigned FAST_HALF_MS = 100;
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned LAMP_TEST_MS = 250;

    localparam int unsigned HOLD_CYC      = HOLD_MS * CLK_KHZ;
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;
    localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CLK_KHZ;
    localparam int unsigned LAMP_TEST_CYC = LAMP_TEST_MS * CLK_KHZ;

    localparam int unsigned CNT_W = 32;
    localparam int unsigned MODE_W = 3;

    localparam logic [2:0] MODE_SELFTEST   = 3'h0;
    localparam logic [2:0] MODE_CONFIG_IO  = 3'h1;
    localparam logic [2:0] MODE_BOOT_WAIT  = 3'h2;
    localparam logic [2:0] MODE_RUN        = 3'h3;
    localparam logic [2:0] MODE_STOP_IO    = 3'h4;
    localparam logic [2:0] MODE_STOP_NOIO  = 3'h5;
    localparam logic [2:0] MODE_STOP_FAULT = 3'h6;
    localparam logic [2:0] MODE_DIAG_FATAL = 3'h7;

    typedef enum logic [1:0] {LT_IDLE, LT_AMBER, LT_GREEN} lamp_test_t;
endpackage

// File: rtl/status_lamp_controller.sv
// Purpose: Drives both front-panel lamp groups from processor, port and
//          network state, and handles the mode switch and restart button.
// Assumes: State inputs are on mclk; panel pins are asynchronous.
// Notes:   Every lamp and action output is a flip-flop.
`timescale 1ns/1ns
module status_lamp_controller #(
    parameter int unsigned HOLD_CYCLES = lamp_pkg::HOLD_CYC,
    parameter int unsigned FAST_HALF   = lamp_pkg::FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF   = lamp_pkg::SLOW_HALF_CYC,
    parameter int unsigned TEST_CYCLES = lamp_pkg::LAMP_TEST_CYC
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    // Panel pins
    input  wire logic                        supply_5v_in,
    input  wire logic                        mode_switch_run,
    input  wire logic                        restart_pressed,
    // Processor state
    input  wire logic [lamp_pkg::MODE_W-1:0] cpu_mode,
    input  wire logic                        cpu_problem,
    input  wire logic                        io_table_clear,
    input  wire logic                        plc_table_clear,
    input  wire logic                        override_active,
    input  wire logic                        port1_busy,
    input  wire logic                        port2_busy,
    input  wire logic                        port1_cfg_console,
    // Network firmware state
    input  wire logic                        net_operational,
    input  wire logic                        net_online,
    input  wire logic                        net_activity,
    input  wire logic                        net_exception,
    input  wire logic                        net_error_code,
    input  wire logic                        net_wait_cfg,
    input  wire logic                        net_sw_load,
    // Processor lamp group
    output logic                             supply_indicator,
    output logic                             health_lamp,
    output logic                             run_green,
    output logic                             run_amber,
    output logic                             fault_lamp,
    output logic                             override_lamp,
    output logic                             port1_activity_lamp,
    output logic                             port2_activity_lamp,
    // Network lamp group
    output logic                             network_link_indicator,
    output logic                             network_link_amber,
    output logic                             net_stat_green,
    output logic                             net_stat_amber,
    output logic                             port1_own_green,
    output logic                             port1_own_amber,
    // Actions
    output logic                             net_hw_reset,
    output logic                             port1_forced,
    output logic                             clear_and_run
);
    import lamp_pkg::*;

    localparam logic [CNT_W-1:0] HOLD_M1 = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] FAST_M1 = CNT_W'(FAST_HALF - 1);
    localparam logic [CNT_W-1:0] SLOW_M1 = CNT_W'(SLOW_HALF - 1);
    localparam logic [CNT_W-1:0] TEST_M1 = CNT_W'(TEST_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0]       pw_s;
        logic [2:0]       sw_s;
        logic [2:0]       bt_s;
        logic             pw_q;
        logic             sw_q;
        logic             bt_q;
        logic [CNT_W-1:0] fast_cnt;
        logic [CNT_W-1:0] slow_cnt;
        logic [CNT_W-1:0] press_cnt;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] lt_cnt;
        logic             fast_ph;
        logic             slow_ph;
        logic             long_done;
        logic             forced;
        logic             run_win;
        logic             tog_stop;
        logic             fault_hold;
        lamp_test_t       lt;
        logic             sup;
        logic             health;
        logic             run_g;
        logic             run_a;
        logic             fault;
        logic             ovr;
        logic             p1_act;
        logic             p2_act;
        logic             link_g;
        logic             link_a;
        logic             stat_g;
        logic             stat_a;
        logic             own_g;
        logic             own_a;
        logic             hw_rst;
        logic             clr_run;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // A pin change is taken only once the second and third stages agree,
    // so a single metastable sample can never reach the decode.
    function automatic logic filt(input logic [2:0] s, input logic q);
        return (s[1] == s[2]) ? s[2] : q;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic sw_new;
        logic bt_new;
        logic sw_rise;
        logic sw_fall;
        logic console;
        sw_new  = filt(st_reg.sw_s, st_reg.sw_q);
        bt_new  = filt(st_reg.bt_s, st_reg.bt_q);
        sw_rise = sw_new && !st_reg.sw_q;
        sw_fall = !sw_new && st_reg.sw_q;
        console = port1_cfg_console || st_reg.forced;
        st_next = st_reg;

        st_next.pw_s = {st_reg.pw_s[1:0], supply_5v_in};
        st_next.sw_s = {st_reg.sw_s[1:0], mode_switch_run};
        st_next.bt_s = {st_reg.bt_s[1:0], restart_pressed};
        st_next.pw_q = filt(st_reg.pw_s, st_reg.pw_q);
        st_next.sw_q = sw_new;
        st_next.bt_q = bt_new;

        if (st_reg.fast_cnt == FAST_M1) begin
            st_next.fast_cnt = '0;
            st_next.fast_ph  = !st_reg.fast_ph;
        end else begin
            st_next.fast_cnt = st_reg.fast_cnt + 1'b1;
        end
        if (st_reg.slow_cnt == SLOW_M1) begin
            st_next.slow_cnt = '0;
            st_next.slow_ph  = !st_reg.slow_ph;
        end else begin
            st_next.slow_cnt = st_reg.slow_cnt + 1'b1;
        end

        // Restart button: long hold toggles port 1, short press restarts.
        st_next.hw_rst = 1'b0;
        if (st_reg.bt_q && bt_new) begin
            if (!st_reg.long_done) begin
                st_next.press_cnt = st_reg.press_cnt + 1'b1;
            end
            if (!st_reg.long_done && st_reg.press_cnt == HOLD_M1) begin
                st_next.long_done = 1'b1;
                // A port configured for the console is never toggled.
                if (!port1_cfg_console) begin
                    st_next.forced = !st_reg.forced;
                end
            end
        end else begin
            st_next.press_cnt = '0;
            st_next.long_done = 1'b0;
        end
        if (st_reg.bt_q && !bt_new && !st_reg.long_done) begin
            st_next.hw_rst = 1'b1;
        end

        unique case (st_reg.lt)
            LT_IDLE: begin
                if (st_reg.bt_q && !bt_new && !st_reg.long_done
                    && net_operational) begin
                    st_next.lt     = LT_AMBER;
                    st_next.lt_cnt = '0;
                end
            end
            LT_AMBER: begin
                st_next.lt_cnt = st_reg.lt_cnt + 1'b1;
                if (st_reg.lt_cnt == TEST_M1) begin
                    st_next.lt     = LT_GREEN;
                    st_next.lt_cnt = '0;
                end
            end
            LT_GREEN: begin
                st_next.lt_cnt = st_reg.lt_cnt + 1'b1;
                if (st_reg.lt_cnt == TEST_M1) begin
                    st_next.lt = LT_IDLE;
                end
            end
        endcase

        // Retry window after a stop-to-run move with a fatal fault.
        st_next.clr_run = 1'b0;
        if (!st_reg.run_win) begin
            if (sw_rise && cpu_mode == MODE_STOP_FAULT) begin
                st_next.run_win  = 1'b1;
                st_next.win_cnt  = '0;
                st_next.tog_stop = 1'b0;
            end
        end else begin
            st_next.win_cnt = st_reg.win_cnt + 1'b1;
            if (sw_fall) begin
                st_next.tog_stop = 1'b1;
            end
            if (sw_rise && st_reg.tog_stop) begin
                st_next.clr_run = 1'b1;
                st_next.run_win = 1'b0;
            end else if (st_reg.win_cnt == HOLD_M1) begin
                st_next.run_win = 1'b0;
            end
        end

        // The fault flag is set by the mode and survives until both
        // tables report clear; setting wins over clearing.
        if (cpu_mode == MODE_STOP_FAULT) begin
            st_next.fault_hold = 1'b1;
        end else if (io_table_clear && plc_table_clear) begin
            st_next.fault_hold = 1'b0;
        end

        st_next.sup    = st_reg.pw_q;
        st_next.run_g  = 1'b0;
        st_next.run_a  = 1'b0;
        st_next.health = 1'b1;
        unique case (cpu_mode)
            MODE_SELFTEST:   st_next.health = st_reg.fast_ph;
            MODE_CONFIG_IO:  st_next.health = st_reg.slow_ph;
            MODE_BOOT_WAIT: begin
                st_next.health = st_reg.slow_ph;
                st_next.run_g  = st_reg.slow_ph;
            end
            MODE_RUN:        st_next.run_g  = 1'b1;
            MODE_STOP_IO:    st_next.run_a  = 1'b1;
            MODE_STOP_NOIO:  st_next.run_g  = 1'b0;
            MODE_STOP_FAULT: st_next.run_g  = 1'b0;
            MODE_DIAG_FATAL: st_next.health = 1'b0;
        endcase
        if (cpu_problem) begin
            st_next.health = 1'b0;
        end
        if (st_reg.run_win) begin
            st_next.run_g = st_reg.fast_ph;
            st_next.run_a = 1'b0;
        end
        st_next.fault = st_reg.fault_hold
            || (cpu_mode == MODE_DIAG_FATAL && st_reg.slow_ph);
        st_next.ovr = override_active;
        // Console traffic never shows on the port 1 activity lamp.
        st_next.p1_act = port1_busy && !console && st_reg.fast_ph;
        st_next.p2_act = port2_busy && st_reg.fast_ph;

        // Network lamp group, lowest priority first.
        st_next.link_g = net_online
            && (!net_activity || st_reg.fast_ph);
        st_next.link_a = 1'b0;
        st_next.stat_g = !net_exception;
        st_next.stat_a = net_exception;
        if (net_error_code) begin
            st_next.stat_g = 1'b0;
            st_next.stat_a = st_reg.slow_ph;
        end else if (net_wait_cfg) begin
            st_next.stat_g = st_reg.slow_ph;
            st_next.stat_a = 1'b0;
        end
        st_next.own_g = 1'b0;
        st_next.own_a = console;
        if (st_reg.lt == LT_AMBER) begin
            {st_next.link_g, st_next.stat_g, st_next.own_g} = 3'h0;
            {st_next.link_a, st_next.stat_a, st_next.own_a} = 3'h7;
        end else if (st_reg.lt == LT_GREEN) begin
            {st_next.link_g, st_next.stat_g, st_next.own_g} = 3'h7;
            {st_next.link_a, st_next.stat_a, st_next.own_a} = 3'h0;
        end else if (net_sw_load) begin
            st_next.link_g = st_reg.slow_ph;
            st_next.stat_g = st_reg.slow_ph;
            st_next.own_g  = st_reg.slow_ph;
            {st_next.link_a, st_next.stat_a, st_next.own_a} = 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    assign supply_indicator       = st_reg.sup;
    assign health_lamp            = st_reg.health;
    assign run_green              = st_reg.run_g;
    assign run_amber              = st_reg.run_a;
    assign fault_lamp             = st_reg.fault;
    assign override_lamp          = st_reg.ovr;
    assign port1_activity_lamp    = st_reg.p1_act;
    assign port2_activity_lamp    = st_reg.p2_act;
    assign network_link_indicator = st_reg.link_g;
    assign network_link_amber     = st_reg.link_a;
    assign net_stat_green         = st_reg.stat_g;
    assign net_stat_amber         = st_reg.stat_a;
    assign port1_own_green        = st_reg.own_g;
    assign port1_own_amber        = st_reg.own_a;
    assign net_hw_reset           = st_reg.hw_rst;
    assign port1_forced           = st_reg.forced;
    assign clear_and_run          = st_reg.clr_run;
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    sequence short_release;
        $fell(st_reg.bt_q) && !$past(st_reg.long_done);
    endsequence
    sequence retry_toggle;
        $past(st_reg.run_win) && $past(st_reg.tog_stop)
            && $rose(st_reg.sw_q);
    endsequence
    a_supply_follow: assert property (
        supply_5v_in [*6] |=> supply_indicator)
        else $error("supply lamp not lit with 5 V present");
    a_health_fatal: assert property (
        (cpu_mode == MODE_DIAG_FATAL) [*2] |-> !health_lamp)
        else $error("health lamp lit after fatal self-check");
    a_run_amber: assert property (
        (cpu_mode == MODE_STOP_IO && !st_reg.run_win) [*2]
            |-> run_amber && !run_green)
        else $error("run lamp not amber in stop with scan");
    a_noio_dark: assert property (
        (cpu_mode == MODE_STOP_NOIO && !st_reg.run_win
            && !cpu_problem) [*2]
            |-> !run_green && !run_amber && health_lamp)
        else $error("stop without scan shows wrong lamps");
    a_fault_set: assert property (
        cpu_mode == MODE_STOP_FAULT |=> ##1 fault_lamp)
        else $error("fault lamp not lit when stopped faulted");
    a_fault_holds: assert property (
        st_reg.fault_hold && !(io_table_clear && plc_table_clear)
            |=> fault_lamp)
        else $error("fault lamp went out with a table not clear");
    a_override_lamp: assert property (
        override_active [*2] |-> ##1 override_lamp)
        else $error("override lamp not lit");
    a_console_quiet: assert property (
        (port1_cfg_console) [*2] |-> !port1_activity_lamp)
        else $error("port 1 lamp blinks for console traffic");
    a_short_press: assert property (
        short_release |-> net_hw_reset)
        else $error("short press gave no network reset");
    a_lamp_test: assert property (
        short_release ##0 $past(net_operational)
            |=> network_link_amber && net_stat_amber && port1_own_amber)
        else $error("lamp test did not start amber");
    a_long_toggle: assert property (
        $rose(st_reg.long_done) && !$past(port1_cfg_console)
            |-> port1_forced != $past(port1_forced))
        else $error("long press did not toggle port 1");
    a_load_unison: assert property (
        (net_sw_load && st_reg.lt == LT_IDLE) [*2]
            |-> network_link_indicator == net_stat_green
                && net_stat_green == port1_own_green)
        else $error("network lamps not in unison during load");
    a_retry_run: assert property (
        retry_toggle |-> clear_and_run && !st_reg.run_win)
        else $error("switch toggle in retry window did not run");
    // The window must close on the edge after its last counted cycle.
    a_retry_bound: assert property (
        st_reg.run_win && st_reg.win_cnt == HOLD_M1 |=> !st_reg.run_win)
        else $error("retry window outlived its hold time");
endmodule

// File: sim/lamp_panel.sv
// Purpose: Operator model that watches every lamp over a window.
// Assumes: Lamps are sampled on the rising edge of mclk.
// Notes:   A lamp seen both lit and dark in one window is blinking.
`timescale 1ns/1ns
module lamp_panel (
    // Clock and window control
    input  wire logic        mclk,
    input  wire logic        clear,
    // Lamps
    input  wire logic [13:0] lamps,
    // Observations
    output logic      [13:0] lit_seen,
    output logic      [13:0] dark_seen
);
    always_ff @(posedge mclk) begin
        if (clear) begin
            lit_seen  <= '0;
            dark_seen <= '0;
        end else begin
            lit_seen  <= lit_seen | lamps;
            dark_seen <= dark_seen | ~lamps;
        end
    end
endmodule

// File: sim/test_status_lamp_controller.sv
// Purpose: Self-checking bench for the front-panel lamp controller.
// Assumes: Short sim counts: hold 40, fast 4, slow 10, lamp test 6.
// Notes:   Blinking is judged by the panel model over a window.
`timescale 1ns/1ns
module test_status_lamp_controller;
    import lamp_pkg::*;
    logic mclk, nrst, clear, supply_5v_in, mode_switch_run, restart_pressed;
    logic cpu_problem, io_table_clear, plc_table_clear, override_active;
    logic port1_busy, port2_busy, port1_cfg_console, net_operational;
    logic net_online, net_activity, net_exception, net_error_code;
    logic net_wait_cfg, net_sw_load;
    logic [2:0] cpu_mode;
    logic supply_indicator, health_lamp, run_green, run_amber, fault_lamp;
    logic override_lamp, port1_activity_lamp, port2_activity_lamp;
    logic network_link_indicator, network_link_amber, net_stat_green;
    logic net_stat_amber, port1_own_green, port1_own_amber;
    logic net_hw_reset, port1_forced, clear_and_run, hit;
    logic [13:0] lamps, lit_seen, dark_seen;
    int err_count, total_checks, diffs;
    assign lamps = {supply_indicator, health_lamp, run_green, run_amber,
        fault_lamp, override_lamp, port1_activity_lamp, port2_activity_lamp,
        network_link_indicator, network_link_amber, net_stat_green,
        net_stat_amber, port1_own_green, port1_own_amber};
    status_lamp_controller #(.HOLD_CYCLES(40), .FAST_HALF(4),
        .SLOW_HALF(10), .TEST_CYCLES(6)) u_status_lamp_controller (.*);
    lamp_panel u_lamp_panel (.mclk(mclk), .clear(clear), .lamps(lamps),
        .lit_seen(lit_seen), .dark_seen(dark_seen));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic watch(input int n, input logic [13:0] m, on, bl);
        clear = 1'b1;
        tick(1);
        clear = 1'b0;
        tick(n);
        check(lit_seen & ~dark_seen & m, on);
        check(lit_seen & dark_seen & m, bl);
    endtask
    task automatic mode_case(input logic [2:0] md, input logic [13:0] on, bl);
        cpu_mode = md;
        tick(3);
        watch(30, 14'h1C00, on, bl);
    endtask
    task automatic net_case(input logic [5:0] v, input logic [13:0] on, bl);
        {net_online, net_activity, net_exception, net_error_code,
            net_wait_cfg, net_sw_load} = v;
        tick(3);
        watch(30, 14'h003F, on, bl);
    endtask
    task automatic press(input int n);
        restart_pressed = 1'b1;
        tick(n);
        restart_pressed = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_supply;
        supply_5v_in = 1'b1;
        tick(6);
        check(supply_indicator, 1'b1);
        supply_5v_in = 1'b0;
        tick(6);
        check(supply_indicator, 1'b0);
        supply_5v_in = 1'b1;
    endtask
    task automatic test_modes;
        mode_case(MODE_RUN, 14'h1800, 14'h0000);
        mode_case(MODE_STOP_IO, 14'h1400, 14'h0000);
        mode_case(MODE_STOP_NOIO, 14'h1000, 14'h0000);
        mode_case(MODE_SELFTEST, 14'h0000, 14'h1000);
        mode_case(MODE_CONFIG_IO, 14'h0000, 14'h1000);
        mode_case(MODE_BOOT_WAIT, 14'h0000, 14'h1800);
        diffs = 0;
        for (int i = 0; i < 24; i++) begin
            tick(1);
            diffs += int'(health_lamp !== run_green);
        end
        check(16'(diffs), 16'h0000);
        cpu_mode = MODE_RUN;
        cpu_problem = 1'b1;
        tick(3);
        watch(30, 14'h1000, 14'h0000, 14'h0000);
        cpu_problem = 1'b0;
    endtask
    task automatic test_fault;
        mode_case(MODE_STOP_FAULT, 14'h1000, 14'h0000);
        check(fault_lamp, 1'b1);
        cpu_mode = MODE_RUN;
        io_table_clear = 1'b1;
        tick(4);
        check(fault_lamp, 1'b1);
        plc_table_clear = 1'b1;
        tick(4);
        check(fault_lamp, 1'b0);
        cpu_mode = MODE_DIAG_FATAL;
        tick(3);
        watch(30, 14'h1200, 14'h0000, 14'h0200);
    endtask
    task automatic test_ports;
        {override_active, port1_busy, port2_busy} = 3'h7;
        tick(3);
        watch(30, 14'h01C3, 14'h0100, 14'h00C0);
        port1_cfg_console = 1'b1;
        tick(3);
        watch(30, 14'h0083, 14'h0001, 14'h0000);
        {port1_cfg_console, override_active, port1_busy, port2_busy} = 4'h0;
    endtask
    task automatic test_net;
        net_operational = 1'b1;
        net_case(6'h20, 14'h0028, 14'h0000);
        net_case(6'h30, 14'h0008, 14'h0020);
        net_case(6'h28, 14'h0024, 14'h0000);
        net_case(6'h24, 14'h0020, 14'h0004);
        net_case(6'h22, 14'h0020, 14'h0008);
        net_case(6'h21, 14'h0000, 14'h002A);
        net_case(6'h00, 14'h0008, 14'h0000);
        net_case(6'h20, 14'h0028, 14'h0000);
    endtask
    task automatic test_restart;
        press(10);
        hit = 1'b0;
        for (int i = 0; i < 12 && !hit; i++) begin
            tick(1);
            hit = (net_hw_reset === 1'b1);
        end
        check(hit, 1'b1);
        tick(2);
        check(lamps[5:0], 6'h15);
        tick(6);
        check(lamps[5:0], 6'h2A);
        check(port1_forced, 1'b0);
    endtask
    task automatic test_long_press;
        press(50);
        tick(8);
        check(port1_forced, 1'b1);
        check(port1_own_amber, 1'b1);
        press(50);
        tick(8);
        check(port1_forced, 1'b0);
    endtask
    task automatic test_retry;
        {io_table_clear, plc_table_clear} = 2'h0;
        cpu_mode = MODE_STOP_FAULT;
        mode_switch_run = 1'b1;
        tick(7);
        watch(12, 14'h0A00, 14'h0200, 14'h0800);
        mode_switch_run = 1'b0;
        tick(6);
        mode_switch_run = 1'b1;
        hit = 1'b0;
        for (int i = 0; i < 14 && !hit; i++) begin
            tick(1);
            hit = (clear_and_run === 1'b1);
        end
        check(hit, 1'b1);
        mode_switch_run = 1'b0;
        tick(6);
        mode_switch_run = 1'b1;
        tick(50);
        watch(10, 14'h0800, 14'h0000, 14'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // The longest run is under 1000 cycles, so this leaves ample margin.
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    initial begin
        err_count = 0;
        total_checks = 0;
        nrst = 1'b0;
        clear = 1'b0;
        {supply_5v_in, mode_switch_run, restart_pressed, cpu_problem} = 4'h0;
        {io_table_clear, plc_table_clear, override_active} = 3'h0;
        {port1_busy, port2_busy, port1_cfg_console, net_operational} = 4'h0;
        {net_online, net_activity, net_exception, net_error_code} = 4'h0;
        {net_wait_cfg, net_sw_load} = 2'h0;
        cpu_mode = MODE_SELFTEST;
        tick(8);
        check({lamps, net_hw_reset, port1_forced}, 16'h0000);
        nrst = 1'b1;
        tick(2);
        test_supply();
        test_modes();
        test_fault();
        test_ports();
        test_net();
        test_restart();
        test_long_press();
        test_retry();
        finish_test();
    end
endmodule
